// ### verilog/dscp_pkg.sv
package dscp_pkg;
	// ----------------------------------------
	// clock plan
	// ----------------------------------------
	// the clock port carries the pll output; every slower rate is a divide of it
	localparam int XTAL_KHZ = 24576;
	localparam int PLL_KHZ = 196608;
	localparam int HALF_KHZ = 98304;
	localparam int LINK_KHZ = 49152;
	localparam int PLL_MULT = PLL_KHZ / XTAL_KHZ;
	localparam int LINK_DIV = PLL_KHZ / LINK_KHZ;
	localparam int HALF_DIV = PLL_KHZ / HALF_KHZ;
	localparam logic [1:0] PHASE_LAST = 2'(LINK_DIV - 1);
	localparam logic [1:0] PHASE_HIGH = 2'(LINK_DIV / 2);
	localparam logic [1:0] HALF_MASK = 2'(HALF_DIV - 1);

	// ----------------------------------------
	// link control line codes
	// ----------------------------------------
	localparam logic [1:0] CTL_IDLE = 2'h0;
	localparam logic [1:0] CTL_STATUS = 2'h1;
	localparam logic [1:0] CTL_RECEIVE = 2'h2;
	localparam logic [1:0] CTL_TRANSMIT = 2'h3;
	localparam logic [1:0] LCTL_IDLE = 2'h0;
	localparam logic [1:0] LCTL_HOLD = 2'h1;
	localparam logic [1:0] LCTL_TRANSMIT = 2'h2;

	// ----------------------------------------
	// modes, speeds, request framing
	// ----------------------------------------
	localparam logic [1:0] STD_1995 = 2'h3;
	localparam logic [1:0] STD_AMEND = 2'h2;
	localparam logic [1:0] SPD_S100 = 2'h0;
	localparam logic [1:0] SPD_S200 = 2'h1;
	localparam logic [2:0] BITS_S100 = 3'h2;
	localparam logic [2:0] BITS_S200 = 3'h4;
	localparam int REQ_BITS = 6;
	localparam logic [2:0] REQ_LAST = 3'(REQ_BITS - 1);
	localparam logic [2:0] REQ_TYPE_REG = 3'h4;
	localparam logic [3:0] DATA_PREFIX = 4'hf;
	localparam logic [3:0] DATA_ZERO = 4'h0;

	// ----------------------------------------
	// cable sense vector layout and quiet times
	// ----------------------------------------
	localparam int SIG_A = 0;
	localparam int SIG_B = 1;
	localparam int SIG_SPD = 2;
	localparam int SIG_BIAS = 3;
	localparam int RX_IDLE_CYC = 16;
	localparam int SETTLE_CYC = 64;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_GRANT = 2'b01,
		ST_TX = 2'b10,
		ST_RX = 2'b11
	} dscp_state_e;
endpackage

// ### verilog/dscp_cable_port.sv
module dscp_cable_port #(
	parameter int IDLE_CYC = dscp_pkg::RX_IDLE_CYC
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic a_cmp_in,
	input wire logic b_cmp_in,
	input wire logic a_speed_in,
	input wire logic b_bias_in,
	input wire logic tx_en,
	input wire logic tx_bit,
	input wire logic tx_bit_stb,
	output logic a_out,
	output logic a_oe,
	output logic b_out,
	output logic b_oe,
	output logic rx_bit,
	output logic rx_stb,
	output logic rx_active,
	output logic connected,
	output logic speed_hi
);
	localparam int IW = $clog2(IDLE_CYC + 1);

	logic [3:0] s1_r, s2_r;
	logic par_r, par_nxt;
	logic rxb_r, rxb_nxt;
	logic rxs_r, rxs_nxt;
	logic [IW-1:0] idle_r, idle_nxt;
	logic dat_r, dat_nxt;
	logic stb_r, stb_nxt;
	logic en_r, en_nxt;
	logic conn_r, conn_nxt;
	logic spd_r, spd_nxt;

	// ----------------------------------------
	// decode and encode
	// ----------------------------------------
	always_comb begin
		par_nxt = s2_r[dscp_pkg::SIG_A] ^ s2_r[dscp_pkg::SIG_B];
		// a change of data xor strobe is the recovered bit clock
		rxs_nxt = (par_nxt != par_r) && !en_r;
		rxb_nxt = rxs_nxt ? s2_r[dscp_pkg::SIG_A] : rxb_r;
		idle_nxt = idle_r;
		if (rxs_nxt) begin
			idle_nxt = IW'(IDLE_CYC);
		end else if (idle_r != '0) begin
			idle_nxt = idle_r - IW'(1);
		end
		en_nxt = tx_en;
		dat_nxt = dat_r;
		stb_nxt = stb_r;
		if (!tx_en) begin
			dat_nxt = 1'b0;
			stb_nxt = 1'b0;
		end else if (tx_bit_stb) begin
			// strobe toggles only when the data bit repeats
			dat_nxt = tx_bit;
			stb_nxt = (tx_bit == dat_r) ? ~stb_r : stb_r;
		end
		conn_nxt = s2_r[dscp_pkg::SIG_BIAS];
		// speed is only sensed between packets, while arbitration runs
		spd_nxt = (idle_r == '0) ? s2_r[dscp_pkg::SIG_SPD] : spd_r;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s1_r <= 4'h0;
			s2_r <= 4'h0;
			par_r <= 1'b0;
			rxb_r <= 1'b0;
			rxs_r <= 1'b0;
			idle_r <= '0;
			dat_r <= 1'b0;
			stb_r <= 1'b0;
			en_r <= 1'b0;
			conn_r <= 1'b0;
			spd_r <= 1'b0;
		end else begin
			s1_r <= {b_bias_in, a_speed_in, b_cmp_in, a_cmp_in};
			s2_r <= s1_r;
			par_r <= par_nxt;
			rxb_r <= rxb_nxt;
			rxs_r <= rxs_nxt;
			idle_r <= idle_nxt;
			dat_r <= dat_nxt;
			stb_r <= stb_nxt;
			en_r <= en_nxt;
			conn_r <= conn_nxt;
			spd_r <= spd_nxt;
		end
	end

	assign a_out = stb_r;
	assign b_out = dat_r;
	assign a_oe = en_r;
	assign b_oe = en_r;
	assign rx_bit = rxb_r;
	assign rx_stb = rxs_r;
	assign rx_active = (idle_r != '0);
	assign connected = conn_r;
	assign speed_hi = spd_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	chk_ds_one_edge: assert property (
		(tx_bit_stb && tx_en && en_r) |=> ((a_out ^ b_out) != $past(a_out ^ b_out))
	) else $error("data-strobe pair did not change by exactly one edge");
	chk_rx_data_pair: assert property (
		rx_stb |-> (rx_bit == $past(s2_r[dscp_pkg::SIG_A]))
	) else $error("received bit not taken from pair a");
	chk_rx_needs_edge: assert property (
		rx_stb |-> ($past(s2_r[dscp_pkg::SIG_A] ^ s2_r[dscp_pkg::SIG_B]) != $past(par_r))
	) else $error("bit recovered without a data-strobe transition");
	chk_bias_connect: assert property (
		s2_r[dscp_pkg::SIG_BIAS] |=> connected ##1 (connected || !$past(s2_r[dscp_pkg::SIG_BIAS]))
	) else $error("sensed bias not reported as connected");
endmodule

// ### verilog/dscp_phy.sv
// Overview of operation
// - clock port carries pll output from crystal
// - divide pll clock to half and quarter
// - quarter clock runs logic, drives link
// - cable bits timed on pll clocks
// - link data latched on link clock
// - serialise at 98.304 or 196.608 Mb/s
// - transmit data on b, strobe on a
// - receiving port transmitters off, receivers on
// - receive data on a, strobe on b
// - decode data-strobe into clock and bits
// - deserialise, resync, deliver to link
// - repeat received bits on other ports
// - pair a common mode picks speed
// - pair b bias means port connected
// - comparator outputs set cable, arbitration state
// - three ports, two transceivers each
// - initialise, arbitrate, monitor port status
// - link lines driven by one side only
// - standard select chooses operating mode
module dscp_phy #(
	parameter int NPORTS = 3,
	parameter int RX_IDLE_CYC = dscp_pkg::RX_IDLE_CYC
) (
	input wire logic clock,
	input wire logic reset,
	output logic link_clock_out,
	input wire logic link_request_in,
	input wire logic [1:0] link_ctrl_lines_in,
	output logic [1:0] link_ctrl_lines_out,
	output logic link_ctrl_lines_oe,
	input wire logic [3:0] link_data_in,
	output logic [3:0] link_data_out,
	output logic link_data_oe,
	input wire logic [1:0] standard_select_pins,
	output logic std_amended,
	input wire logic [NPORTS-1:0] cable_pair_a_in,
	input wire logic [NPORTS-1:0] cable_pair_b_in,
	input wire logic [NPORTS-1:0] cable_pair_a_speed_in,
	input wire logic [NPORTS-1:0] cable_pair_b_bias_in,
	output logic [NPORTS-1:0] cable_pair_a_out,
	output logic [NPORTS-1:0] cable_pair_a_oe,
	output logic [NPORTS-1:0] cable_pair_b_out,
	output logic [NPORTS-1:0] cable_pair_b_oe,
	output logic [NPORTS-1:0] port_connected
);
	localparam int PW = (NPORTS > 1) ? $clog2(NPORTS) : 1;
	localparam int SW = $clog2(dscp_pkg::SETTLE_CYC + 1);

	function automatic logic [2:0] grp_bits(input logic [1:0] spd);
		return (spd == dscp_pkg::SPD_S200) ? dscp_pkg::BITS_S200 : dscp_pkg::BITS_S100;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [1:0] phase_r, phase_nxt;
	logic clk_r, clk_nxt;
	logic [8:0] lsync1_r, lsync2_r;
	logic link_request_in_s;
	logic [1:0] ctl_s, std_s;
	logic [3:0] data_s;
	logic tick, std_ok;
	logic [5:0] req_sh_r, req_sh_nxt, req_full;
	logic [2:0] req_cnt_r, req_cnt_nxt;
	logic req_busy_r, req_busy_nxt, req_pend_r, req_pend_nxt;
	logic [1:0] req_speed_r, req_speed_nxt;
	logic [NPORTS-1:0] conn_prev_r;
	logic [SW-1:0] settle_r, settle_nxt;
	dscp_pkg::dscp_state_e state_r, state_nxt;
	logic [1:0] tx_speed_r, tx_speed_nxt;
	logic [3:0] tx_sh_r, tx_sh_nxt;
	logic [2:0] tx_left_r, tx_left_nxt;
	logic tx_stb;
	logic [PW-1:0] rx_port_r, rx_port_nxt, first_port;
	logic found;
	logic [1:0] rx_speed_r, rx_speed_nxt;
	logic [3:0] rx_acc_r, rx_acc_nxt, grp_r, grp_nxt;
	logic [2:0] rx_cnt_r, rx_cnt_nxt;
	logic grp_vld_r, grp_vld_nxt;
	logic [1:0] ctl_out_r, ctl_out_nxt;
	logic [3:0] dat_out_r, dat_out_nxt;
	logic ctl_oe_r, ctl_oe_nxt, dat_oe_r, dat_oe_nxt, amend_r;
	logic [NPORTS-1:0] p_rx_bit, p_rx_stb, p_rx_active, p_conn, p_speed;
	logic [NPORTS-1:0] p_tx_en, p_tx_bit, p_tx_stb;
	logic sel_bit, sel_stb;

	assign link_request_in_s = lsync2_r[8];
	assign ctl_s = lsync2_r[7:6];
	assign data_s = lsync2_r[5:2];
	assign std_s = lsync2_r[1:0];
	// the link samples on its rising edge, mid-way through our four-phase cycle
	assign tick = (phase_r == dscp_pkg::PHASE_LAST);
	assign std_ok = (std_s == dscp_pkg::STD_1995) || (std_s == dscp_pkg::STD_AMEND);
	assign req_full = {req_sh_r[4:0], link_request_in_s};
	assign sel_bit = p_rx_bit[rx_port_r];
	assign sel_stb = p_rx_stb[rx_port_r];
	// s100 sends on every second pll edge (98.304), s200 on every edge
	assign tx_stb = (state_r == dscp_pkg::ST_TX) && (tx_left_r != 3'h0)
		&& ((tx_speed_r == dscp_pkg::SPD_S200)
		|| ((phase_r & dscp_pkg::HALF_MASK) == dscp_pkg::HALF_MASK));

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		found = 1'b0;
		first_port = '0;
		for (int i = 0; i < NPORTS; i++) begin
			if (!found && p_rx_active[i] && p_conn[i]) begin
				found = 1'b1;
				first_port = PW'(i);
			end
		end
		phase_nxt = tick ? 2'h0 : phase_r + 2'h1;
		clk_nxt = (phase_nxt >= dscp_pkg::PHASE_HIGH);

		req_sh_nxt = req_sh_r;
		req_cnt_nxt = req_cnt_r;
		req_busy_nxt = req_busy_r;
		req_pend_nxt = req_pend_r;
		req_speed_nxt = req_speed_r;
		// serial request: start bit, three type bits, two speed bits, stop
		if (tick) begin
			if (req_busy_r) begin
				req_sh_nxt = req_full;
				req_cnt_nxt = req_cnt_r + 3'h1;
				if (req_cnt_r == dscp_pkg::REQ_LAST) begin
					req_busy_nxt = 1'b0;
				end
			end else if (link_request_in_s) begin
				req_busy_nxt = 1'b1;
				req_cnt_nxt = 3'h0;
			end
		end

		// any connection change restarts a quiet period before arbitration
		settle_nxt = settle_r;
		if (p_conn != conn_prev_r) begin
			settle_nxt = SW'(dscp_pkg::SETTLE_CYC);
		end else if (settle_r != '0) begin
			settle_nxt = settle_r - SW'(1);
		end

		state_nxt = state_r;
		tx_speed_nxt = tx_speed_r;
		tx_sh_nxt = tx_sh_r;
		tx_left_nxt = tx_left_r;
		rx_port_nxt = rx_port_r;
		rx_speed_nxt = rx_speed_r;
		rx_acc_nxt = rx_acc_r;
		rx_cnt_nxt = rx_cnt_r;
		grp_nxt = grp_r;
		grp_vld_nxt = grp_vld_r;
		if (tx_stb) begin
			tx_sh_nxt = {tx_sh_r[2:0], 1'b0};
			tx_left_nxt = tx_left_r - 3'h1;
		end
		case (state_r)
			dscp_pkg::ST_IDLE: begin
				if (found) begin
					// receive starts at once so no leading bit is lost
					state_nxt = dscp_pkg::ST_RX;
					rx_port_nxt = first_port;
					rx_speed_nxt = p_speed[first_port] ? dscp_pkg::SPD_S200
						: dscp_pkg::SPD_S100;
					// the transition that woke us already carries the first bit
					rx_acc_nxt = {3'h0, p_rx_bit[first_port]};
					rx_cnt_nxt = p_rx_stb[first_port] ? 3'h1 : 3'h0;
					grp_vld_nxt = 1'b0;
				end else if (tick && req_pend_r && settle_r == '0) begin
					state_nxt = dscp_pkg::ST_GRANT;
					tx_speed_nxt = req_speed_r;
					req_pend_nxt = 1'b0;
				end
			end
			dscp_pkg::ST_GRANT: begin
				if (tick) begin
					state_nxt = dscp_pkg::ST_TX;
					tx_left_nxt = 3'h0;
				end
			end
			dscp_pkg::ST_TX: begin
				if (tick) begin
					case (ctl_s)
						dscp_pkg::LCTL_TRANSMIT: begin
							// latch a link group; its last old bit left this same edge
							tx_sh_nxt = (tx_speed_r == dscp_pkg::SPD_S200) ? data_s
								: {data_s[3:2], 2'h0};
							tx_left_nxt = grp_bits(tx_speed_r);
						end
						dscp_pkg::LCTL_IDLE: begin
							state_nxt = dscp_pkg::ST_IDLE;
						end
						default: begin
						end
					endcase
				end
			end
			dscp_pkg::ST_RX: begin
				if (sel_stb) begin
					rx_acc_nxt = {rx_acc_r[2:0], sel_bit};
					rx_cnt_nxt = rx_cnt_r + 3'h1;
					if (rx_cnt_r + 3'h1 == grp_bits(rx_speed_r)) begin
						grp_nxt = (rx_speed_r == dscp_pkg::SPD_S200)
							? {rx_acc_r[2:0], sel_bit} : {rx_acc_r[0], sel_bit, 2'h0};
						grp_vld_nxt = 1'b1;
						rx_cnt_nxt = 3'h0;
					end
				end
				if (tick && !p_rx_active[rx_port_r]) begin
					state_nxt = dscp_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = dscp_pkg::ST_IDLE;
			end
		endcase
		// a request that completes while a grant clears the old one is kept
		if (tick && req_busy_r && req_cnt_r == dscp_pkg::REQ_LAST && std_ok
			&& req_full[5:3] < dscp_pkg::REQ_TYPE_REG) begin
			req_pend_nxt = 1'b1;
			req_speed_nxt = req_full[2:1];
		end

		// link lines change only at the link clock boundary
		ctl_out_nxt = ctl_out_r;
		ctl_oe_nxt = ctl_oe_r;
		dat_out_nxt = dat_out_r;
		dat_oe_nxt = dat_oe_r;
		if (tick) begin
			ctl_oe_nxt = 1'b1;
			dat_oe_nxt = 1'b1;
			dat_out_nxt = dscp_pkg::DATA_ZERO;
			case (state_nxt)
				dscp_pkg::ST_GRANT: ctl_out_nxt = dscp_pkg::CTL_TRANSMIT;
				dscp_pkg::ST_TX: begin
					ctl_oe_nxt = 1'b0;
					dat_oe_nxt = 1'b0;
					ctl_out_nxt = dscp_pkg::CTL_IDLE;
				end
				dscp_pkg::ST_RX: begin
					// a group finishing on this edge goes out now rather than being dropped
					ctl_out_nxt = dscp_pkg::CTL_RECEIVE;
					dat_out_nxt = grp_vld_nxt ? grp_nxt : dscp_pkg::DATA_PREFIX;
					grp_vld_nxt = 1'b0;
				end
				default: ctl_out_nxt = dscp_pkg::CTL_IDLE;
			endcase
		end

		for (int i = 0; i < NPORTS; i++) begin
			// the receiving port stays silent, the other connected ports repeat it
			p_tx_en[i] = p_conn[i] && ((state_r == dscp_pkg::ST_TX)
				|| (state_r == dscp_pkg::ST_RX && rx_port_r != PW'(i))
				|| (state_r == dscp_pkg::ST_IDLE && found && first_port != PW'(i)));
			p_tx_bit[i] = (state_r == dscp_pkg::ST_TX) ? tx_sh_r[3]
				: (state_r == dscp_pkg::ST_RX) ? sel_bit : p_rx_bit[first_port];
			p_tx_stb[i] = (state_r == dscp_pkg::ST_TX) ? tx_stb
				: (state_r == dscp_pkg::ST_RX) ? sel_stb : p_rx_stb[first_port];
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			phase_r <= 2'h0;
			clk_r <= 1'b0;
			lsync1_r <= 9'h000;
			lsync2_r <= 9'h000;
			req_sh_r <= 6'h00;
			req_cnt_r <= 3'h0;
			req_busy_r <= 1'b0;
			req_pend_r <= 1'b0;
			req_speed_r <= dscp_pkg::SPD_S100;
			conn_prev_r <= '0;
			settle_r <= SW'(dscp_pkg::SETTLE_CYC);
			state_r <= dscp_pkg::ST_IDLE;
			tx_speed_r <= dscp_pkg::SPD_S100;
			tx_sh_r <= 4'h0;
			tx_left_r <= 3'h0;
			rx_port_r <= '0;
			rx_speed_r <= dscp_pkg::SPD_S100;
			rx_acc_r <= 4'h0;
			rx_cnt_r <= 3'h0;
			grp_r <= 4'h0;
			grp_vld_r <= 1'b0;
			ctl_out_r <= dscp_pkg::CTL_IDLE;
			ctl_oe_r <= 1'b1;
			dat_out_r <= dscp_pkg::DATA_ZERO;
			dat_oe_r <= 1'b1;
			amend_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			clk_r <= clk_nxt;
			lsync1_r <= {link_request_in, link_ctrl_lines_in, link_data_in,
				standard_select_pins};
			lsync2_r <= lsync1_r;
			req_sh_r <= req_sh_nxt;
			req_cnt_r <= req_cnt_nxt;
			req_busy_r <= req_busy_nxt;
			req_pend_r <= req_pend_nxt;
			req_speed_r <= req_speed_nxt;
			conn_prev_r <= p_conn;
			settle_r <= settle_nxt;
			state_r <= state_nxt;
			tx_speed_r <= tx_speed_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_left_r <= tx_left_nxt;
			rx_port_r <= rx_port_nxt;
			rx_speed_r <= rx_speed_nxt;
			rx_acc_r <= rx_acc_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			grp_r <= grp_nxt;
			grp_vld_r <= grp_vld_nxt;
			ctl_out_r <= ctl_out_nxt;
			ctl_oe_r <= ctl_oe_nxt;
			dat_out_r <= dat_out_nxt;
			dat_oe_r <= dat_oe_nxt;
			amend_r <= (std_s == dscp_pkg::STD_AMEND);
		end
	end

	// ----------------------------------------
	// cable ports
	// ----------------------------------------
	for (genvar g = 0; g < NPORTS; g++) begin : g_port
		dscp_cable_port #(.IDLE_CYC(RX_IDLE_CYC)) u_port (
			.clock(clock),
			.reset(reset),
			.a_cmp_in(cable_pair_a_in[g]),
			.b_cmp_in(cable_pair_b_in[g]),
			.a_speed_in(cable_pair_a_speed_in[g]),
			.b_bias_in(cable_pair_b_bias_in[g]),
			.tx_en(p_tx_en[g]),
			.tx_bit(p_tx_bit[g]),
			.tx_bit_stb(p_tx_stb[g]),
			.a_out(cable_pair_a_out[g]),
			.a_oe(cable_pair_a_oe[g]),
			.b_out(cable_pair_b_out[g]),
			.b_oe(cable_pair_b_oe[g]),
			.rx_bit(p_rx_bit[g]),
			.rx_stb(p_rx_stb[g]),
			.rx_active(p_rx_active[g]),
			.connected(p_conn[g]),
			.speed_hi(p_speed[g])
		);
	end

	assign link_clock_out = clk_r;
	assign link_ctrl_lines_out = ctl_out_r;
	assign link_ctrl_lines_oe = ctl_oe_r;
	assign link_data_out = dat_out_r;
	assign link_data_oe = dat_oe_r;
	assign std_amended = amend_r;
	assign port_connected = p_conn;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_rx_held;
		(state_r == dscp_pkg::ST_RX) ##1 (state_r == dscp_pkg::ST_RX);
	endsequence

	chk_link_clock_div: assert property (
		$rose(link_clock_out) |-> ##2 $fell(link_clock_out) ##2 $rose(link_clock_out)
	) else $error("link clock is not a divide by four");
	chk_link_own_tx: assert property (
		(state_r == dscp_pkg::ST_TX) |-> (!link_data_oe && !link_ctrl_lines_oe)
	) else $error("device drives link lines while the link owns them");
	chk_grant_drive: assert property (
		(state_r == dscp_pkg::ST_GRANT) |-> (link_ctrl_lines_oe
			&& link_ctrl_lines_out == dscp_pkg::CTL_TRANSMIT)
	) else $error("grant not shown on the control lines");
	chk_rx_port_quiet: assert property (
		s_rx_held |-> (!cable_pair_a_oe[rx_port_r] && !cable_pair_b_oe[rx_port_r])
	) else $error("receiving port transmitter still enabled");
	chk_tx_latch: assert property (
		(tick && state_r == dscp_pkg::ST_TX && ctl_s == dscp_pkg::LCTL_TRANSMIT)
			|=> (tx_sh_r[3:2] == $past(data_s[3:2]))
	) else $error("link data not latched at the link clock boundary");
	chk_serial_rate: assert property (
		(tx_stb && tx_speed_r == dscp_pkg::SPD_S100) |=> !tx_stb
	) else $error("s100 bits sent faster than half the pll rate");
endmodule

// ### test/dscp_link_model.sv
module dscp_link_model (
	input wire logic clock,
	input wire logic link_clock_out,
	input wire logic [1:0] ctl_out,
	input wire logic ctl_oe,
	input wire logic [3:0] data_out,
	input wire logic data_oe,
	output logic link_request,
	output logic [1:0] ctl_in,
	output logic [3:0] data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] ctl_drv = 2'h0;
	logic [3:0] data_drv = 4'h0;
	initial link_request = 1'b0;
	// ----
	// shared lines: whoever holds the enable owns the wire
	// ----
	assign ctl_in = ctl_oe ? ctl_out : ctl_drv;
	assign data_in = data_oe ? data_out : data_drv;
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// bits change just after a tick so the 2-flop sync settles before the next one
	task automatic request(input logic [2:0] kind, input logic [1:0] spd);
		logic [6:0] frame;
		frame = {1'b1, kind, spd, 1'b0};
		@(negedge link_clock_out);
		for (int i = 6; i >= 0; i--) begin
			idle(1);
			link_request = frame[i];
			idle(3);
		end
	endtask
	task automatic transmit(input logic [15:0] bits, input int w, input int n, output logic g);
		int t;
		g = 1'b0;
		for (t = 0; t < 400 && !g; t++) begin
			idle(1);
			g = ctl_oe && ctl_out === dscp_pkg::CTL_TRANSMIT;
		end
		if (g) begin
			for (t = 0; t < 16 && ctl_oe; t++)
				idle(1);
			for (int k = 0; k < n; k++) begin
				ctl_drv = dscp_pkg::LCTL_TRANSMIT;
				data_drv = w == 4 ? bits[15 - 4 * k -: 4] : {bits[15 - 2 * k -: 2], 2'h0};
				idle(4);
			end
			ctl_drv = dscp_pkg::LCTL_IDLE;
			idle(12);
		end
	endtask
endmodule

// ### test/dscp_phy_tb.sv
module dscp_phy_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// stimulus and observed signals
	// ----
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [1:0] sel = 2'h3;
	logic [2:0] a_in = 3'h0, b_in = 3'h0, spd = 3'h0, bias = 3'h0;
	logic lclk, req, ctl_oe, d_oe, amd, g, pl;
	logic [1:0] ctl_in, ctl_out;
	logic [3:0] d_in, d_out;
	logic [2:0] a_out, a_oe, b_out, b_oe, conn, pa, pb;
	logic [15:0] v;
	bit txq[3][$];
	logic [3:0] rxq[$];
	int errors = 0, checked = 0, rxw = 4;
	always #2 clock = ~clock;
	dscp_phy #(.NPORTS(3), .RX_IDLE_CYC(16)) dut (.clock(clock), .reset(reset),
		.link_clock_out(lclk), .link_request_in(req), .link_ctrl_lines_in(ctl_in),
		.link_ctrl_lines_out(ctl_out), .link_ctrl_lines_oe(ctl_oe), .link_data_in(d_in),
		.link_data_out(d_out), .link_data_oe(d_oe), .standard_select_pins(sel),
		.std_amended(amd), .cable_pair_a_in(a_in), .cable_pair_b_in(b_in),
		.cable_pair_a_speed_in(spd), .cable_pair_b_bias_in(bias), .cable_pair_a_out(a_out),
		.cable_pair_a_oe(a_oe), .cable_pair_b_out(b_out), .cable_pair_b_oe(b_oe),
		.port_connected(conn));
	dscp_link_model lnk (.clock(clock), .link_clock_out(lclk), .ctl_out(ctl_out),
		.ctl_oe(ctl_oe), .data_out(d_out), .data_oe(d_oe), .link_request(req),
		.ctl_in(ctl_in), .data_in(d_in));
	// ----
	// monitors: a data-strobe bit is any change of the pair, its value is pair b
	// ----
	always @(negedge clock) begin
		for (int p = 0; p < 3; p++)
			if (a_oe[p] && {a_out[p], b_out[p]} !== {pa[p], pb[p]})
				txq[p].push_back(b_out[p]);
		if (pl && !lclk && ctl_oe && ctl_out === dscp_pkg::CTL_RECEIVE)
			rxq.push_back(rxw == 4 ? d_out : {d_out[3:2], 2'h0});
		pa = a_out;
		pb = b_out;
		pl = lclk;
	end
	function automatic logic [3:0] grp(input logic [15:0] bits, input int w, input int k);
		return w == 4 ? bits[15 - 4 * k -: 4] : {bits[15 - 2 * k -: 2], 2'h0};
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic cmp_bits(input int p, input logic [15:0] bits, input int nb);
		check("bit count", txq[p].size(), nb);
		for (int i = 0; i < nb && i < txq[p].size(); i++)
			check("cable bit", txq[p][i], bits[15 - i]);
	endtask
	// data on pair a, strobe on pair b toggles only when the bit repeats
	task automatic cable_send(input logic [15:0] bits, input int nb, input int per);
		for (int i = 0; i < nb; i++) begin
			if (a_in[0] === bits[15 - i])
				b_in[0] = ~b_in[0];
			else
				a_in[0] = bits[15 - i];
			step(per);
		end
	endtask
	task automatic test_done();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#80000;
		errors++;
		test_done();
	end
	// ----
	// main sequence
	// ----
	initial begin
		void'($urandom(78260));
		step(4);
		check("link clock", lclk, 0);
		check("ctl oe", ctl_oe, 1);
		check("cable oe", {a_oe, b_oe}, 0);
		check("connected", conn, 0);
		reset = 1'b0;
		for (int k = 1; k <= 8; k++) begin
			step(1);
			check("link clock", lclk, k % 4 >= 2);
		end
		for (int i = 0; i < 8; i++) begin
			sel = i < 4 ? i[1:0] : 2'($urandom);
			step(3);
			check("amended", amd, sel == dscp_pkg::STD_AMEND);
		end
		for (int i = 0; i < 6; i++) begin
			bias = i < 5 ? 3'($urandom) : 3'h3;
			step(3);
			check("connected", conn, bias);
		end
		// refused: two bus-request types out of range, then a reserved select code
		for (int i = 0; i < 3; i++) begin
			sel = i == 2 ? 2'h1 : dscp_pkg::STD_1995;
			step(80);
			lnk.request(i == 2 ? 3'h1 : 3'h4 + 3'(3 * i), dscp_pkg::SPD_S200);
			lnk.transmit(16'h0, 4, 0, g);
			check("refused grant", g, 0);
		end
		for (int i = 0; i < 4; i++) begin
			sel = i[0] ? dscp_pkg::STD_AMEND : dscp_pkg::STD_1995;
			rxw = i < 2 ? 4 : 2;
			v = 16'($urandom);
			step(3);
			for (int p = 0; p < 3; p++)
				txq[p].delete();
			lnk.request(3'($urandom % 4), rxw == 4 ? dscp_pkg::SPD_S200 : dscp_pkg::SPD_S100);
			lnk.transmit(v, rxw, 2, g);
			check("grant", g, 1);
			cmp_bits(0, v, 2 * rxw);
			cmp_bits(1, v, 2 * rxw);
			check("idle port", txq[2].size(), 0);
		end
		for (int i = 0; i < 2; i++) begin
			rxw = i ? 2 : 4;
			spd[0] = !i;
			v = 16'($urandom) & 16'h7fff;
			step(8);
			rxq.delete();
			for (int p = 0; p < 3; p++)
				txq[p].delete();
			cable_send(v, 8, i ? 2 : 1);
			check("rx port oe", {a_oe[0], b_oe[0]}, 0);
			check("rx status", ctl_out, dscp_pkg::CTL_RECEIVE);
			step(40);
			check("rx end", ctl_out, dscp_pkg::CTL_IDLE);
			while (rxq.size() > 0 && rxq[0] === (rxw == 4 ? 4'hf : 4'hc))
				void'(rxq.pop_front());
			for (int k = 0; k < 8 / rxw; k++)
				check("rx group", rxq[k], grp(v, rxw, k));
			cmp_bits(1, v, 8);
		end
		test_done();
	end
endmodule
